/* core/spi_eeprom_front.v */
// Serial front end of a byte-alterable memory: framing, pause and status.
//
// Operation
// - Output bits on falling edge, reads and status fetch only
// - Sample input bits on rising edge, MSB first
// - Chip select high floats output three clocks later, after the pin synchroniser
// - Pause starts: pause low, clock low
// - Pause ends when pause high, clock low
// - Deselect while paused mid-byte abandons the transaction
// - No selection before first chip select fall
// - Write runs only when all conditions hold
// - Misaligned chip select rise discards a write
// - Reads shift out until chip select rises
// - Standby only when no write cycle runs, bar the first clock after a commit
// - Status bits 6, 5, 4 read zero
// - Busy from write commit at chip select rise until cycle ends
// - Latch clear: writes decoded, not executed
// - Latch set, cleared by disable, completion
// - Guard bits change only by status store
// - Guard encoding selects protected address range
// - Lock bit zero: status always writable
// - Lock with guard pin low discards store
// - Locked condition left only by guard high
// - Opcode byte first, fixed opcode values
// - Unknown opcode waits for chip select high
// - Status fetch repeats while selected
// - Status store changes lock and guards only
`timescale 1ns/100ps
`include "spi_eeprom_map.vh"

module spi_eeprom_front (
   input wire clk,                // System clock, 125 MHz.
   input wire resetn,             // Synchronous reset, active low.
   input wire sclk,               // Serial clock pin.
   input wire cs_n,               // Chip select pin, active low.
   input wire mosi,               // Serial data in pin.
   input wire hold_n,             // Pause pin, active low.
   input wire guard_n,            // Status guard pin, active low.
   output reg miso,               // Serial data out level.
   output reg miso_oe,            // Serial data out enable.
   input wire [2:0] nv_init,      // Stored lock and guard bits.
   output reg [7:0] status_byte,  // Status register image.
   output reg standby,            // Low power state.
   output reg rd_fetch,           // Read data wanted.
   output reg [12:0] rd_addr,     // Address of next byte wanted.
   input wire rd_valid,           // Read byte offered.
   input wire [7:0] rd_data,      // Read byte.
   output reg rd_ready,           // Read byte accepted.
   output reg wr_data_stb,        // Write data byte pulse.
   output reg [7:0] wr_data,      // Write data byte.
   output reg [12:0] wr_addr,     // Write start address.
   output reg wr_commit,          // Start array write cycle pulse.
   output reg wr_abort,           // Drop streamed bytes pulse.
   output reg wr_to_status,       // Cycle targets status bits.
   input wire wr_done             // Write cycle finished pulse.
);

   localparam ST_OP = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_OUT = 3'h3;
   localparam ST_WAIT = 3'h4;

   // Two flip-flop synchronisers for every pin.
   reg [4:0] pin_a_q;
   reg [4:0] pin_b_q;
   reg sclk_prev_q;
   reg cs_prev_q;

   reg armed_q;
   reg paused_q;
   reg [2:0] state_q;
   reg [2:0] bit_q;
   reg [2:0] bytes_q;
   reg [7:0] sr_q;
   reg [7:0] op_q;
   reg [12:0] addr_q;
   reg [7:0] store_q;
   reg store_seen_q;
   reg streamed_q;

   reg [7:0] out_q;
   reg [2:0] obit_q;

   reg wel_q;
   reg busy_q;
   reg lock_q;
   reg [1:0] guard_q;
   reg [2:0] pend_q;

   reg [7:0] buf0_q;
   reg [7:0] buf1_q;
   reg [1:0] cnt_q;

   wire s_sclk = pin_b_q[0];
   wire s_cs_n = pin_b_q[1];
   wire s_mosi = pin_b_q[2];
   wire s_hold_n = pin_b_q[3];
   wire s_guard_n = pin_b_q[4];

   wire rise = s_sclk & ~sclk_prev_q;
   wire fall = ~s_sclk & sclk_prev_q;
   wire cs_fall = ~s_cs_n & cs_prev_q;
   wire cs_rise = s_cs_n & ~cs_prev_q;
   wire selected = armed_q & ~s_cs_n;
   wire live = selected & ~paused_q;
   wire in_edge = live & rise;
   wire out_edge = live & fall & (state_q == ST_OUT);
   wire byte_done = in_edge & (bit_q == `BIT_LAST);
   wire [7:0] byte_in = {sr_q[6:0], s_mosi};
   wire boundary = (bit_q == 3'h0);

   wire [7:0] status = {lock_q, `SR_ZERO_FIELD, guard_q, wel_q, busy_q};

   // The lock only bites while the guard pin is low, whichever came last.
   wire locked = lock_q & ~s_guard_n;

   reg guarded;
   always @* begin
      case (guard_q)
         `GUARD_NONE: guarded = 1'b0;
         `GUARD_QUARTER: guarded = (addr_q >= `QUARTER_BASE);
         `GUARD_HALF: guarded = (addr_q >= `HALF_BASE);
         default: guarded = 1'b1;
      endcase
   end

   wire op_wen = (op_q == `OP_ENABLE_WRITES);
   wire op_wdis = (op_q == `OP_DISABLE_WRITES);
   wire op_sst = (op_q == `OP_STATUS_STORE);
   wire op_wr = (op_q == `OP_ARRAY_WRITE);
   wire op_rd = (op_q == `OP_ARRAY_READ);

   wire commit_sst = cs_rise & armed_q & boundary & op_sst & store_seen_q &
      wel_q & ~locked & ~busy_q;
   wire commit_wr = cs_rise & armed_q & boundary & op_wr &
      (bytes_q >= `BYTES_MIN_WRITE) & wel_q & ~guarded & ~busy_q;
   wire exec_wen = cs_rise & armed_q & boundary & op_wen &
      (bytes_q == `BYTES_OPCODE);
   wire exec_wdis = cs_rise & armed_q & boundary & op_wdis &
      (bytes_q == `BYTES_OPCODE);

   wire fetch_on = selected & (state_q == ST_OUT) & op_rd;
   wire pop = out_edge & (obit_q == 3'h0) & op_rd & (cnt_q != 2'h0);
   wire push = rd_valid & rd_ready;
   wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   always @(posedge clk) begin
      if (!resetn) begin
         // Select starts as low, so one held low at power-up never arms.
         pin_a_q <= `PINS_AT_RESET;
         pin_b_q <= `PINS_AT_RESET;
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end else begin
         pin_a_q <= {guard_n, hold_n, mosi, cs_n, sclk};
         pin_b_q <= pin_a_q;
         sclk_prev_q <= s_sclk;
         cs_prev_q <= s_cs_n;
      end
   end

   // Framing, pause and the input shifter.
   always @(posedge clk) begin
      if (!resetn) begin
         armed_q <= 1'b0;
         paused_q <= 1'b0;
         state_q <= ST_OP;
         bit_q <= 3'h0;
         bytes_q <= 3'h0;
         sr_q <= 8'h00;
         op_q <= 8'h00;
         addr_q <= 13'h0000;
         store_q <= 8'h00;
         store_seen_q <= 1'b0;
         streamed_q <= 1'b0;
      end else begin
         if (cs_fall)
            armed_q <= 1'b1;
         if (!selected) begin
            // Deselect drops the frame state, a paused frame included; sr_q, addr_q and store_q keep their values.
            paused_q <= 1'b0;
            state_q <= ST_OP;
            bit_q <= 3'h0;
            bytes_q <= 3'h0;
            op_q <= 8'h00;
            store_seen_q <= 1'b0;
            streamed_q <= 1'b0;
         end else begin
            if (!paused_q && !s_hold_n && !s_sclk)
               paused_q <= 1'b1;
            else if (paused_q && s_hold_n && !s_sclk)
               paused_q <= 1'b0;
            if (in_edge) begin
               sr_q <= byte_in;
               bit_q <= bit_q + 3'h1;
            end
            if (byte_done) begin
               if (bytes_q != `BYTES_MAX)
                  bytes_q <= bytes_q + 3'h1;
               case (state_q)
                  ST_OP: begin
                     op_q <= byte_in;
                     case (byte_in)
                        `OP_ENABLE_WRITES: state_q <= ST_WAIT;
                        `OP_DISABLE_WRITES: state_q <= ST_WAIT;
                        `OP_STATUS_FETCH: state_q <= ST_OUT;
                        `OP_STATUS_STORE:
                           state_q <= busy_q ? ST_WAIT : ST_DATA;
                        `OP_ARRAY_READ:
                           state_q <= busy_q ? ST_WAIT : ST_ADDR;
                        `OP_ARRAY_WRITE:
                           state_q <= busy_q ? ST_WAIT : ST_ADDR;
                        default: state_q <= ST_WAIT;
                     endcase
                  end
                  ST_ADDR: begin
                     // Upper address bits above the array are ignored.
                     addr_q <= {addr_q[4:0], byte_in};
                     if (bytes_q == `BYTES_HEADER - 3'h1)
                        state_q <= op_rd ? ST_OUT : ST_DATA;
                  end
                  ST_DATA: begin
                     if (op_sst) begin
                        store_q <= byte_in;
                        store_seen_q <= 1'b1;
                     end else begin
                        streamed_q <= 1'b1;
                     end
                  end
                  default: state_q <= state_q;
               endcase
            end
         end
      end
   end

   // Output shifter; a byte is loaded on the first falling edge of each slot.
   always @(posedge clk) begin
      if (!resetn) begin
         out_q <= 8'h00;
         obit_q <= 3'h0;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         if (state_q != ST_OUT) begin
            obit_q <= 3'h0;
         end else if (out_edge) begin
            obit_q <= obit_q + 3'h1;
            if (obit_q == 3'h0) begin
               if (op_rd) begin
                  out_q <= cnt_q != 2'h0 ? buf0_q : `IDLE_FILL;
                  miso <= cnt_q != 2'h0 ? buf0_q[7] : 1'b1;
               end else begin
                  out_q <= status;
                  miso <= status[7];
               end
            end else begin
               out_q <= {out_q[6:0], 1'b0};
               miso <= out_q[6];
            end
         end
         miso_oe <= live & (state_q == ST_OUT);
      end
   end

   // Two-entry read buffer between the array port and the output shifter.
   // A slow array port is seen by the master as a run of ones.
   always @(posedge clk) begin
      if (!resetn) begin
         buf0_q <= 8'h00;
         buf1_q <= 8'h00;
         cnt_q <= 2'h0;
         rd_fetch <= 1'b0;
         rd_addr <= 13'h0000;
         rd_ready <= 1'b0;
      end else begin
         rd_fetch <= fetch_on;
         if (!fetch_on) begin
            cnt_q <= 2'h0;
            rd_ready <= 1'b0;
            // A byte taken as the frame ends still counts as taken.
            rd_addr <= push ? rd_addr + 13'h0001 : addr_q;
         end else begin
            cnt_q <= cnt_d;
            rd_ready <= (cnt_d < `BUF_DEPTH);
            // The address shifter settles only as the output phase begins.
            if (!rd_fetch)
               rd_addr <= addr_q;
            else if (push)
               rd_addr <= rd_addr + 13'h0001;
            if (pop) begin
               buf0_q <= (push && cnt_q == 2'h1) ? rd_data : buf1_q;
               if (push && cnt_q == 2'h2)
                  buf1_q <= rd_data;
            end else if (push) begin
               if (cnt_q == 2'h0)
                  buf0_q <= rd_data;
               else
                  buf1_q <= rd_data;
            end
         end
      end
   end

   // Write stream towards the array and the write cycle handshake.
   always @(posedge clk) begin
      if (!resetn) begin
         wr_data_stb <= 1'b0;
         wr_data <= 8'h00;
         wr_addr <= 13'h0000;
         wr_commit <= 1'b0;
         wr_abort <= 1'b0;
         wr_to_status <= 1'b0;
      end else begin
         wr_data_stb <= byte_done & (state_q == ST_DATA) & op_wr;
         if (byte_done && state_q == ST_DATA && op_wr)
            wr_data <= byte_in;
         if (state_q == ST_DATA && op_wr)
            wr_addr <= addr_q;
         wr_commit <= commit_wr;
         // Bytes already streamed are thrown away on a refused frame.
         wr_abort <= cs_rise & armed_q & op_wr & streamed_q & ~commit_wr;
         if (commit_wr || commit_sst)
            wr_to_status <= commit_sst;
      end
   end

   // Status bits; the lock and guard bits start from their stored copy.
   always @(posedge clk) begin
      if (!resetn) begin
         wel_q <= 1'b0;
         busy_q <= 1'b0;
         lock_q <= nv_init[2];
         guard_q <= nv_init[1:0];
         pend_q <= 3'h0;
         status_byte <= 8'h00;
         standby <= 1'b0;
      end else begin
         if (wr_done && busy_q) begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            if (wr_to_status) begin
               lock_q <= pend_q[2];
               guard_q <= pend_q[1:0];
            end
         end
         if (exec_wdis)
            wel_q <= 1'b0;
         if (exec_wen)
            wel_q <= 1'b1;
         if (commit_sst)
            pend_q <= {store_q[`SR_LOCK_BIT], store_q[`SR_GUARD_HI_BIT],
               store_q[`SR_GUARD_LO_BIT]};
         if (commit_wr || commit_sst)
            busy_q <= 1'b1;
         status_byte <= status;
         standby <= ~selected & ~busy_q;
      end
   end

endmodule

/* core/spi_eeprom_map.vh */
// Opcodes, status bit positions and protection bounds of the serial front end.
`ifndef SPI_EEPROM_MAP_VH
`define SPI_EEPROM_MAP_VH

`define OP_ENABLE_WRITES 8'h06
`define OP_DISABLE_WRITES 8'h04
`define OP_STATUS_FETCH 8'h05
`define OP_STATUS_STORE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02

`define SR_LOCK_BIT 7
`define SR_GUARD_HI_BIT 3
`define SR_GUARD_LO_BIT 2
`define SR_WEL_BIT 1
`define SR_BUSY_BIT 0
`define SR_ZERO_FIELD 3'h0

`define GUARD_NONE 2'h0
`define GUARD_QUARTER 2'h1
`define GUARD_HALF 2'h2
`define GUARD_ALL 2'h3
`define QUARTER_BASE 13'h1800
`define HALF_BASE 13'h1000

`define BIT_LAST 3'h7
`define BYTES_OPCODE 3'h1
`define BYTES_HEADER 3'h3
`define BYTES_MIN_WRITE 3'h4
`define BYTES_MAX 3'h7
`define BUF_DEPTH 2'h2
`define IDLE_FILL 8'hff
`define PINS_AT_RESET 5'h1c

`endif

/* verif/spi_eeprom_front_asserts.sv */
// Property checker for the serial front end, bound to its ports.
`timescale 1ns/100ps
module spi_eeprom_front_asserts (
   input wire logic clk, // System clock.
   input wire logic resetn, // Reset, active low.
   input wire logic cs_n, // Chip select.
   input wire logic sclk, // Link clock.
   input wire logic hold_n, // Pause pin.
   input wire logic miso_oe, // Data out enable.
   input wire logic [7:0] status_byte, // Status image.
   input wire logic standby, // Low power flag.
   input wire logic rd_fetch, // Read data wanted.
   input wire logic [12:0] rd_addr, // Read address.
   input wire logic rd_valid, // Read byte offered.
   input wire logic rd_ready, // Read byte taken.
   input wire logic wr_data_stb, // Write byte pulse.
   input wire logic wr_commit, // Commit pulse.
   input wire logic wr_abort // Abort pulse.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Eight cycles leave room for the pin synchroniser before the float.
   sequence paused_s;
      (!hold_n && !sclk)[*8];
   endsequence
   sequence busy_hold_s;
      ##2 (!standby)[*8];
   endsequence
   a_cs_float: assert property (
      $rose(cs_n) |-> ##[1:5] !miso_oe) else $error("output not floated");
   a_zero_bits: assert property (
      status_byte[6:4] == 3'h0) else $error("reserved status bits set");
   a_commit_wel: assert property (
      wr_commit |-> $past(status_byte[1])) else $error("commit without wel");
   a_one_outcome: assert property (
      wr_commit |-> !wr_abort) else $error("commit and abort together");
   a_busy_set: assert property (
      wr_commit |-> ##[1:2] status_byte[0]) else $error("busy not set");
   a_no_standby: assert property (
      wr_commit |-> busy_hold_s) else $error("standby while busy");
   a_rd_step: assert property (
      rd_fetch && rd_valid && rd_ready |=> rd_addr == $past(rd_addr) + 13'h1)
      else $error("read address did not step");
   a_stb_pulse: assert property (
      wr_data_stb |=> !wr_data_stb) else $error("byte pulse too long");
   a_pause_float: assert property (
      paused_s |-> !miso_oe) else $error("output driven while paused");
endmodule

bind spi_eeprom_front spi_eeprom_front_asserts chk (.clk(clk),
   .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .hold_n(hold_n),
   .miso_oe(miso_oe), .status_byte(status_byte), .standby(standby),
   .rd_fetch(rd_fetch), .rd_addr(rd_addr), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .wr_data_stb(wr_data_stb), .wr_commit(wr_commit),
   .wr_abort(wr_abort));

/* verif/spi_master_model.sv */
// Bus master model for the serial link, clock mode 0 or 3.
`timescale 1ns/100ps
module spi_master_model (
   input wire logic clk, // System clock.
   input wire logic miso_pin, // Resolved data out wire.
   output logic sclk, // Link clock.
   output logic cs_n, // Chip select, active low.
   output logic mosi, // Data in.
   output logic hold_n // Pause, active low.
);
   logic cpol = 1'b0;
   logic do_pause = 1'b0;
   // Select starts low so that a power-up without a falling edge is seen.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic sel();
      sclk <= cpol;
      tick(10);
      cs_n <= 1'b0;
      tick(10);
   endtask
   task automatic desel();
      sclk <= cpol;
      tick(10);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      tick(20);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sclk <= 1'b0;
         mosi <= tx[i];
         tick(10);
         if (do_pause && i == 4) begin
            hold_n <= 1'b0;
            tick(10);
            sclk <= 1'b1;
            tick(10);
            sclk <= 1'b0;
            tick(10);
            hold_n <= 1'b1;
            tick(10);
         end
         rx[i] = miso_pin;
         sclk <= 1'b1;
         tick(10);
      end
   endtask
endmodule

/* verif/tb_spi_eeprom_front.sv */
// Self-checking bench for the serial front end.
`timescale 1ns/100ps
`include "spi_eeprom_map.vh"
`define CHK(n, e, g) chk(n, 16'(e), 16'(g));
module tb_spi_eeprom_front;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic guard_n = 1'b1;
   logic rd_valid = 1'b0;
   logic wr_done = 1'b0;
   logic sclk, cs_n, mosi, hold_n, miso, miso_oe, standby, rd_fetch;
   logic rd_ready, wr_data_stb, wr_commit, wr_abort, wr_to_status;
   logic [7:0] status_byte, wr_data, rd_data, rx, s;
   logic [12:0] rd_addr, wr_addr;
   logic [7:0] stb_q[$];
   int fail_count = 0, checked = 0, commits = 0, aborts = 0, busy_t = 0;
   wire miso_pin = miso_oe ? miso : 1'bz;
   assign rd_data = rd_addr[7:0] ^ 8'ha5;
   always #4 clk = ~clk;
   spi_eeprom_front dut (.clk(clk), .resetn(resetn), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .guard_n(guard_n),
      .miso(miso), .miso_oe(miso_oe), .nv_init(3'h0),
      .status_byte(status_byte), .standby(standby), .rd_fetch(rd_fetch),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_ready(rd_ready), .wr_data_stb(wr_data_stb), .wr_data(wr_data),
      .wr_addr(wr_addr), .wr_commit(wr_commit), .wr_abort(wr_abort),
      .wr_to_status(wr_to_status), .wr_done(wr_done));
   spi_master_model m (.clk(clk), .miso_pin(miso_pin), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n));
   // Array side: offers bytes while fetching, ends write cycles late.
   always @(posedge clk) begin
      rd_valid <= rd_fetch;
      busy_t <= status_byte[0] ? busy_t + 1 : 0;
      wr_done <= (busy_t == 600);
      if (wr_commit) commits <= commits + 1;
      if (wr_abort) aborts <= aborts + 1;
      if (wr_data_stb) stb_q.push_back(wr_data);
   end
   task automatic chk(input string n, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic frame(input logic [7:0] a, b, input int nb);
      m.sel();
      m.xfer(a, rx, 8);
      if (nb > 0) m.xfer(b, rx, nb);
      m.desel();
   endtask
   task automatic fetch(output logic [7:0] v);
      m.sel();
      m.xfer(`OP_STATUS_FETCH, rx, 8);
      m.xfer(8'h00, v, 8);
      m.xfer(8'h00, rx, 8);
      m.desel();
      `CHK("status repeat", v, rx)
   endtask
   task automatic wait_ready();
      fetch(s);
      for (int i = 0; i < 8 && s[0] !== 1'b0; i++) fetch(s);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d, input int t);
      m.sel();
      m.xfer(`OP_ARRAY_WRITE, rx, 8);
      m.xfer({3'h0, a[12:8]}, rx, 8);
      m.xfer(a[7:0], rx, 8);
      m.xfer(d, rx, 8);
      if (t > 0) m.xfer(8'hff, rx, t);
      m.desel();
   endtask
   task automatic endt(input string n);
      $display("test %s done", n);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      m.xfer(`OP_ENABLE_WRITES, rx, 8);
      m.desel();
      `CHK("unarmed wel", 1'b0, status_byte[1])
      fetch(s);
      `CHK("status reset", 8'h00, s)
      m.cpol = 1'b1;
      frame(`OP_ENABLE_WRITES, 8'h00, 0);
      m.cpol = 1'b0;
      m.do_pause = 1'b1;
      fetch(s);
      m.do_pause = 1'b0;
      `CHK("wel set", 8'h02, s)
      frame(`OP_DISABLE_WRITES, 8'h00, 0);
      fetch(s);
      `CHK("wel clear", 8'h00, s)
      endt("latch");
      frame(`OP_ENABLE_WRITES, 8'h00, 0);
      frame(`OP_STATUS_STORE, 8'hff, 8);
      fetch(s);
      `CHK("busy", 1'b1, s[0])
      `CHK("to status", 1'b1, wr_to_status)
      wait_ready();
      `CHK("stored", 8'h8c, s)
      guard_n <= 1'b0;
      frame(`OP_ENABLE_WRITES, 8'h00, 0);
      frame(`OP_STATUS_STORE, 8'h00, 8);
      fetch(s);
      `CHK("locked", 8'h8e, s)
      guard_n <= 1'b1;
      frame(`OP_STATUS_STORE, 8'h04, 8);
      wait_ready();
      `CHK("unlocked", 8'h04, s)
      endt("status");
      frame(`OP_ENABLE_WRITES, 8'h00, 0);
      wr(13'h1800, 8'h3c, 0);
      `CHK("guarded", 0, commits)
      wr(13'h17ff, 8'hc3, 0);
      `CHK("commit", 1, commits)
      `CHK("wr addr", 13'h17ff, wr_addr)
      `CHK("to array", 1'b0, wr_to_status)
      `CHK("wr data", 8'hc3, stb_q[$])
      wait_ready();
      wr(13'h0010, 8'h11, 0);
      `CHK("no wel", 1, commits)
      frame(8'haa, `OP_ENABLE_WRITES, 8);
      fetch(s);
      `CHK("unknown op", 8'h04, s)
      frame(`OP_ENABLE_WRITES, 8'h00, 0);
      wr(13'h0100, 8'h5a, 3);
      `CHK("misaligned", 1, commits)
      `CHK("abort", 3, aborts)
      endt("write");
      m.sel();
      m.xfer(`OP_ARRAY_READ, rx, 8);
      m.xfer(8'h01, rx, 8);
      m.xfer(8'h23, rx, 8);
      for (int i = 0; i < 3; i++) begin
         m.xfer(8'h00, rx, 8);
         `CHK("read byte", 8'h23 + i ^ 8'ha5, rx)
      end
      m.desel();
      endt("read");
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
